// *** hw/zc_pkg.sv ***
/*
  Constants, register map and carrier types for the zero-cross detector block.
  Assumes an AXI4-Lite master with 32-bit data and a single 125 MHz clock.
*/
`default_nettype none
package zc_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [3:0] OFS_CONTROL   = 4'h0;
  localparam logic [3:0] OFS_FLAGS     = 4'h4;
  localparam logic [3:0] OFS_FLAG_CLR  = 4'h8;
  localparam logic [3:0] OFS_IRQ_CTRL  = 4'hC;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int BIT_DETECT_ON  = 7;
  localparam int BIT_LEVEL      = 5;
  localparam int BIT_POL_INV    = 4;
  localparam int BIT_RISE_EN    = 1;
  localparam int BIT_FALL_EN    = 0;
  localparam int BIT_IRQ_FLAG   = 0;
  localparam int BIT_ZC_IE      = 0;
  localparam int BIT_PERIPH_IE  = 1;
  localparam int BIT_GLOBAL_IE  = 2;

  // ************************************************************
  // reset values and bus response codes
  // ************************************************************
  localparam logic RST_POL_INV  = 1'h0;
  localparam logic RST_EDGE_EN  = 1'h0;
  localparam logic RST_IE       = 1'h0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic detect_on;
    logic polarity_invert;
    logic rise_irq_en;
    logic fall_irq_en;
  } zc_ctrl_t;

  typedef struct packed {
    logic zc_irq_enable;
    logic peripheral_irq_enable;
    logic global_irq_enable;
  } zc_ie_t;

endpackage
`default_nettype wire

// *** hw/zc_sync2.sv ***
/*
  Two-flop synchroniser for one level.
  Assumes the input may change at any time relative to the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module zc_sync2 (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_async,
  output logic      o_sync
);
  logic stage1;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      stage1 <= 1'h0;
      o_sync <= 1'h0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule
`default_nettype wire

// *** hw/zc_detect.sv ***
/*
  Zero-cross detector digital side: pin drive control, level status with
  polarity, edge-triggered sticky flag, interrupt gating, AXI4-Lite slave.
  Assumes the analogue front end reports which current path is active.
*/
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module zc_detect
  import zc_pkg::*;
(
  input  wire logic        I_MCLK,
  input  wire logic        I_RESET,
  input  wire logic        i_CFG_DETECT_OFF,
  input  wire logic        i_SINK_ACTIVE,
  input  wire logic [31:0] i_AWADDR,
  input  wire logic        i_AWVALID,
  output logic             o_AWREADY,
  input  wire logic [31:0] i_WDATA,
  input  wire logic [3:0]  i_WSTRB,
  input  wire logic        i_WVALID,
  output logic             o_WREADY,
  output logic [1:0]       o_BRESP,
  output logic             o_BVALID,
  input  wire logic        i_BREADY,
  input  wire logic [31:0] i_ARADDR,
  input  wire logic        i_ARVALID,
  output logic             o_ARREADY,
  output logic [31:0]      o_RDATA,
  output logic [1:0]       o_RRESP,
  output logic             o_RVALID,
  input  wire logic        i_RREADY,
  output logic             o_PIN_ZC_MODE,
  output logic             o_IRQ
);

  // ************************************************************
  // control state
  // ************************************************************
  zc_ctrl_t   ctrl;
  zc_ie_t     ie;
  logic       cfg_loaded;
  logic       sink_sync;
  logic       zc_level_status;
  logic       level_prev;
  logic       zc_irq_flag;
  logic       rise_evt;
  logic       fall_evt;
  logic       set_flag;
  logic       clr_flag;
  logic       aw_held;
  logic       w_held;
  logic [3:0] aw_ofs;
  logic [31:0] w_data;
  logic       w_lane0;
  logic       do_write;

  function automatic logic known_ofs(input logic [31:0] addr);
    known_ofs = (addr[31:4] == 28'h0000000) && (addr[1:0] == 2'h0);
  endfunction

  zc_sync2 u_sync (
    .i_clk   (I_MCLK),
    .i_reset (I_RESET),
    .i_async (i_SINK_ACTIVE),
    .o_sync  (sink_sync)
  );

  // ************************************************************
  // level and edges
  // ************************************************************
  // sink active reads one, invert flips it; edges taken after the flip
  assign zc_level_status = sink_sync ^ ctrl.polarity_invert;
  assign rise_evt = zc_level_status & ~level_prev;
  assign fall_evt = ~zc_level_status & level_prev;
  // no gate on detect_on, so a polarity toggle alone can set the flag; no sleep gating
  assign set_flag = (rise_evt & ctrl.rise_irq_en) | (fall_evt & ctrl.fall_irq_en);

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      level_prev <= 1'h0;
    end else begin
      level_prev <= zc_level_status;
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      zc_irq_flag <= 1'h0;
    end else if (set_flag) begin
      zc_irq_flag <= 1'h1;
    end else if (clr_flag) begin
      zc_irq_flag <= 1'h0;
    end
  end

  assign o_IRQ = zc_irq_flag & ie.zc_irq_enable & ie.peripheral_irq_enable
               & ie.global_irq_enable;
  assign o_PIN_ZC_MODE = ctrl.detect_on;

  // ************************************************************
  // write channel
  // ************************************************************
  assign o_AWREADY = ~aw_held & ~o_BVALID;
  assign o_WREADY  = ~w_held & ~o_BVALID;
  assign do_write  = aw_held & w_held & ~o_BVALID;
  assign w_lane0   = i_WSTRB[0];

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      aw_held <= 1'h0;
      w_held  <= 1'h0;
      aw_ofs  <= 4'h0;
      w_data  <= 32'h00000000;
      o_BVALID <= 1'h0;
      o_BRESP  <= RESP_OKAY;
    end else begin
      if (i_AWVALID && o_AWREADY) begin
        aw_held <= 1'h1;
        aw_ofs  <= known_ofs(i_AWADDR) ? i_AWADDR[3:0] : 4'h1;
      end
      if (i_WVALID && o_WREADY) begin
        w_held <= 1'h1;
        w_data <= w_lane0 ? i_WDATA : 32'h00000000;
      end
      if (do_write) begin
        aw_held  <= 1'h0;
        w_held   <= 1'h0;
        o_BVALID <= 1'h1;
        o_BRESP  <= (aw_ofs == OFS_CONTROL || aw_ofs == OFS_FLAGS ||
                     aw_ofs == OFS_FLAG_CLR || aw_ofs == OFS_IRQ_CTRL) ?
                    RESP_OKAY : RESP_SLVERR;
      end else if (o_BVALID && i_BREADY) begin
        o_BVALID <= 1'h0;
      end
    end
  end

  assign clr_flag = do_write && aw_ofs == OFS_FLAG_CLR && w_data[BIT_IRQ_FLAG];

  // detector enable is caught from the strap after reset release
  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      cfg_loaded  <= 1'h0;
      ctrl        <= '{detect_on: 1'h0, polarity_invert: RST_POL_INV,
                       rise_irq_en: RST_EDGE_EN, fall_irq_en: RST_EDGE_EN};
    end else if (!cfg_loaded) begin
      cfg_loaded     <= 1'h1;
      ctrl.detect_on <= ~i_CFG_DETECT_OFF;
    end else if (do_write && aw_ofs == OFS_CONTROL) begin
      ctrl.detect_on       <= w_data[BIT_DETECT_ON];
      ctrl.polarity_invert <= w_data[BIT_POL_INV];
      ctrl.rise_irq_en     <= w_data[BIT_RISE_EN];
      ctrl.fall_irq_en     <= w_data[BIT_FALL_EN];
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      ie <= '{zc_irq_enable: RST_IE, peripheral_irq_enable: RST_IE,
              global_irq_enable: RST_IE};
    end else if (do_write && aw_ofs == OFS_IRQ_CTRL) begin
      ie.zc_irq_enable         <= w_data[BIT_ZC_IE];
      ie.peripheral_irq_enable <= w_data[BIT_PERIPH_IE];
      ie.global_irq_enable     <= w_data[BIT_GLOBAL_IE];
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  assign o_ARREADY = ~o_RVALID;

  always_comb begin
    next_rdata = 32'h00000000;
    next_rresp = RESP_OKAY;
    if (!known_ofs(i_ARADDR)) begin
      next_rresp = RESP_SLVERR;
    end else begin
      case (i_ARADDR[3:0])
        OFS_CONTROL: begin
          next_rdata[BIT_DETECT_ON] = ctrl.detect_on;
          next_rdata[BIT_LEVEL]     = zc_level_status;
          next_rdata[BIT_POL_INV]   = ctrl.polarity_invert;
          next_rdata[BIT_RISE_EN]   = ctrl.rise_irq_en;
          next_rdata[BIT_FALL_EN]   = ctrl.fall_irq_en;
        end
        OFS_FLAGS: begin
          next_rdata[BIT_IRQ_FLAG] = zc_irq_flag;
        end
        OFS_FLAG_CLR: begin
          next_rdata = 32'h00000000;
        end
        OFS_IRQ_CTRL: begin
          next_rdata[BIT_ZC_IE]     = ie.zc_irq_enable;
          next_rdata[BIT_PERIPH_IE] = ie.peripheral_irq_enable;
          next_rdata[BIT_GLOBAL_IE] = ie.global_irq_enable;
        end
        default: begin
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge I_MCLK or posedge I_RESET) begin
    if (I_RESET) begin
      o_RVALID <= 1'h0;
      o_RDATA  <= 32'h00000000;
      o_RRESP  <= RESP_OKAY;
    end else if (i_ARVALID && o_ARREADY) begin
      o_RVALID <= 1'h1;
      o_RDATA  <= next_rdata;
      o_RRESP  <= next_rresp;
    end else if (o_RVALID && i_RREADY) begin
      o_RVALID <= 1'h0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_rise_sets_flag: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (rise_evt && ctrl.rise_irq_en) |=> zc_irq_flag)
    else $error("rising edge did not set flag");

  chk_fall_sets_flag: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (fall_evt && ctrl.fall_irq_en) |=> zc_irq_flag)
    else $error("falling edge did not set flag");

  chk_set_beats_clear: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (set_flag && clr_flag) |=> zc_irq_flag)
    else $error("clear won over set");

  chk_flag_sticky: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (zc_irq_flag && !clr_flag) |=> zc_irq_flag)
    else $error("flag dropped without clear");

  chk_irq_gating: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    o_IRQ == (zc_irq_flag && ie.zc_irq_enable && ie.peripheral_irq_enable
              && ie.global_irq_enable))
    else $error("interrupt gating wrong");

  // starts once both synchroniser stages hold post-reset samples
  chk_level_polarity: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (cfg_loaded && $past(cfg_loaded))
    |-> (zc_level_status == ($past(i_SINK_ACTIVE, 2) ^ ctrl.polarity_invert)))
    else $error("level status polarity wrong");

  chk_sync_delay: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    cfg_loaded |-> ##2 (sink_sync == $past(i_SINK_ACTIVE, 2)))
    else $error("synchroniser delay not two cycles");

  chk_pol_toggle_irq: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    ($changed(ctrl.polarity_invert) && $stable(sink_sync) && ctrl.rise_irq_en
     && ctrl.fall_irq_en && cfg_loaded) |=> zc_irq_flag)
    else $error("polarity toggle did not set flag");

  chk_pin_mode: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    o_PIN_ZC_MODE == ctrl.detect_on)
    else $error("pin mode not following enable");

  chk_strap_load: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    $rose(cfg_loaded) |-> (ctrl.detect_on == !$past(i_CFG_DETECT_OFF)))
    else $error("detector enable strap not loaded");

  // ************************************************************
  // flag, gating and bus protocol checks
  // ************************************************************
  chk_flag_set_only: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (!zc_irq_flag && !set_flag) |=> !zc_irq_flag)
    else $error("flag rose without an enabled edge");

  chk_clear_drops: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (clr_flag && !set_flag) |=> !zc_irq_flag)
    else $error("clear did not drop flag");

  chk_no_edge_no_set: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (!rise_evt && !fall_evt) |-> !set_flag)
    else $error("set without an edge");

  chk_rise_gated: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (rise_evt && !ctrl.rise_irq_en) |-> !set_flag)
    else $error("rising edge set flag while disabled");

  chk_fall_gated: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (fall_evt && !ctrl.fall_irq_en) |-> !set_flag)
    else $error("falling edge set flag while disabled");

  chk_level_prev_track: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    cfg_loaded |=> (level_prev == $past(zc_level_status)))
    else $error("edge history not following level");

  chk_irq_needs_flag: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    !zc_irq_flag |-> !o_IRQ)
    else $error("interrupt without flag");

  chk_ie_write: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (do_write && aw_ofs == OFS_IRQ_CTRL) |=>
    (ie.zc_irq_enable == $past(w_data[BIT_ZC_IE])
     && ie.global_irq_enable == $past(w_data[BIT_GLOBAL_IE])))
    else $error("enable write not applied");

  chk_ctrl_write: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (cfg_loaded && do_write && aw_ofs == OFS_CONTROL) |=>
    (ctrl.detect_on == $past(w_data[BIT_DETECT_ON])
     && ctrl.polarity_invert == $past(w_data[BIT_POL_INV])))
    else $error("control write not applied");

  chk_bvalid_hold: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (o_BVALID && !i_BREADY) |=> (o_BVALID && $stable(o_BRESP)))
    else $error("write response dropped early");

  chk_rvalid_hold: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (o_RVALID && !i_RREADY) |=>
    (o_RVALID && $stable(o_RDATA) && $stable(o_RRESP)))
    else $error("read data dropped early");

  chk_b_after_write: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (aw_held && w_held && !o_BVALID) |=> o_BVALID)
    else $error("no response after address and data");

  chk_r_after_addr: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (i_ARVALID && o_ARREADY) |=> o_RVALID)
    else $error("no read data after address");

  chk_write_busy: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    o_BVALID |-> (!o_AWREADY && !o_WREADY))
    else $error("write accepted while response pending");

  chk_read_busy: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    o_RVALID |-> !o_ARREADY)
    else $error("read accepted while data pending");

  chk_bad_write_resp: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (do_write && aw_ofs == 4'h1) |=> (o_BRESP == RESP_SLVERR))
    else $error("unmapped write not refused");

  chk_bvalid_drop: assert property (@(posedge I_MCLK) disable iff (I_RESET)
    (o_BVALID && i_BREADY) |=> !o_BVALID)
    else $error("write response not retired");

endmodule
`default_nettype wire

// *** tb/zc_line_model.sv ***
/*
  Model of the AC waveform on the detector pin, seen as which current path is active.
  Assumes the bench sets whether the applied voltage is above the threshold.
*/
`timescale 1ns/1ps
`default_nettype none
module zc_line_model (
  input  wire logic i_above,
  output logic      o_sink_active
);
  // ************************************************************
  // front end response
  // ************************************************************
  // pin weak pull-up is kept off, so only the series resistor loads it
  initial o_sink_active = 1'b0;
  // sink above threshold, source below; lands off the clock edge
  always @(i_above) o_sink_active <= #3 i_above;
endmodule
`default_nettype wire

// *** tb/zero_cross_detect_irq_test.sv ***
/*
  Self-checking bench for the zero-cross detector block.
  Assumes zc_pkg, zc_detect and the line model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module zero_cross_detect_irq_test;
  import zc_pkg::*;
  logic        I_MCLK = 0, I_RESET = 1, cfg_off = 0, above = 0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rv;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, sink, pin_mode, irq;
  logic [1:0]  bresp, rresp, resp;
  int          mismatches = 0, total_checks = 0;

  always #4 I_MCLK = ~I_MCLK;

  zc_line_model i_line (.i_above(above), .o_sink_active(sink));
  zc_detect i_dut (
    .I_MCLK(I_MCLK), .I_RESET(I_RESET), .i_CFG_DETECT_OFF(cfg_off), .i_SINK_ACTIVE(sink),
    .i_AWADDR(awaddr), .i_AWVALID(awvalid), .o_AWREADY(awready), .i_WDATA(wdata),
    .i_WSTRB(4'hF), .i_WVALID(wvalid), .o_WREADY(wready), .o_BRESP(bresp),
    .o_BVALID(bvalid), .i_BREADY(bready), .i_ARADDR(araddr), .i_ARVALID(arvalid),
    .o_ARREADY(arready), .o_RDATA(rdata), .o_RRESP(rresp), .o_RVALID(rvalid),
    .i_RREADY(rready), .o_PIN_ZC_MODE(pin_mode), .o_IRQ(irq));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge I_MCLK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge I_MCLK);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge I_MCLK);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge I_MCLK);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rv = rdata;
    resp = rresp;
  endtask

  task automatic do_reset(input logic strap);
    I_RESET <= 1'b1;
    cfg_off <= strap;
    repeat (12) @(posedge I_MCLK);
    I_RESET <= 1'b0;
    repeat (3) @(posedge I_MCLK);
  endtask

  task automatic set_above(input logic v);
    @(posedge I_MCLK);
    above <= v;
    repeat (5) @(posedge I_MCLK);
  endtask

  task automatic arm(input logic [31:0] ctrl);
    set_above(1'b0);
    wr(32'(OFS_CONTROL), ctrl);
    wr(32'(OFS_FLAG_CLR), 32'h1 << BIT_IRQ_FLAG);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    do_reset(1'b0);
    rd(32'(OFS_CONTROL));
    check(rv[BIT_DETECT_ON], 1'b1, "strap clear enable");
    check(resp, RESP_OKAY, "control read resp");
    check(pin_mode, 1'b1, "pin mode on");
    rd(32'h0000_0010);
    check(resp, RESP_SLVERR, "unmapped read");
    wr(32'(OFS_CONTROL), 32'h0);
    check(resp, RESP_OKAY, "control write resp");
    rd(32'(OFS_FLAG_CLR));
    check(pin_mode, 1'b0, "pin mode off");
    do_reset(1'b1);
    rd(32'(OFS_CONTROL));
    check(rv[BIT_DETECT_ON], 1'b0, "strap set enable");
    check(pin_mode, 1'b0, "pin mode strap");
    wr(32'(OFS_CONTROL), 32'h1 << BIT_DETECT_ON);
    check(pin_mode, 1'b1, "pin mode by write");
    wr(32'h0000_0010, 32'h0000_0001);
    check(resp, RESP_SLVERR, "unmapped write");
    $display("test reset done");
  endtask

  task automatic t_level;
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 2; s++) begin
        wr(32'(OFS_CONTROL), 32'(p) << BIT_POL_INV);
        set_above(s[0]);
        rd(32'(OFS_CONTROL));
        check(rv[BIT_LEVEL], s[0] ^ p[0], "level status");
      end
    end
    $display("test level done");
  endtask

  task automatic t_edges;
    for (int k = 0; k < 2; k++) begin
      arm(32'h1 << (k == 0 ? BIT_RISE_EN : BIT_FALL_EN));
      set_above(1'b1);
      repeat (20) @(posedge I_MCLK);
      rd(32'(OFS_FLAGS));
      check(rv[BIT_IRQ_FLAG], k == 0, "rise sets flag");
      wr(32'(OFS_FLAG_CLR), 32'h1);
      set_above(1'b0);
      rd(32'(OFS_FLAGS));
      check(rv[BIT_IRQ_FLAG], k == 1, "fall sets flag");
    end
    $display("test edges done");
  endtask

  task automatic t_irq;
    arm(32'h1 << BIT_RISE_EN);
    set_above(1'b1);
    for (int e = 0; e < 8; e++) begin
      wr(32'(OFS_IRQ_CTRL), 32'(e));
      repeat (2) @(posedge I_MCLK);
      check(irq, e == 7, "irq gating");
    end
    wr(32'(OFS_FLAG_CLR), 32'h1);
    repeat (2) @(posedge I_MCLK);
    check(irq, 1'b0, "irq after clear");
    $display("test irq done");
  endtask

  task automatic t_pol;
    arm((32'h1 << BIT_RISE_EN) | (32'h1 << BIT_FALL_EN));
    wr(32'(OFS_CONTROL), (32'h1 << BIT_POL_INV) | 32'h3);
    repeat (5) @(posedge I_MCLK);
    rd(32'(OFS_FLAGS));
    check(rv[BIT_IRQ_FLAG], 1'b1, "polarity toggle edge");
    $display("test polarity done");
  endtask

  task automatic t_race;
    for (int d = 0; d < 4; d += 3) begin
      arm(32'h1 << BIT_RISE_EN);
      @(posedge I_MCLK);
      above <= 1'b1;
      repeat (d) @(posedge I_MCLK);
      wr(32'(OFS_FLAG_CLR), 32'h1);
      repeat (4) @(posedge I_MCLK);
      rd(32'(OFS_FLAGS));
      check(rv[BIT_IRQ_FLAG], d == 0, "set against clear");
    end
    $display("test race done");
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    t_reset();
    t_level();
    t_edges();
    t_irq();
    t_pol();
    t_race();
    results();
  end

  initial begin
    #200000;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
